// *** verilog/spcr_pkg.sv ***
// Package with the map, field layout and types of the serial port configuration registers.
package spcr_pkg;
	localparam int AW = 13;
	localparam logic [12:0] ADDR_PORT_SETUP = 13'h000;
	localparam logic [12:0] ADDR_VARIANT = 13'h003;
	localparam logic [12:0] ADDR_READBACK = 13'h004;
	localparam logic [12:0] ADDR_NV_A = 13'hB02;
	localparam logic [12:0] ADDR_NV_B = 13'hB03;
	localparam logic [12:0] ADDR_GEN_BASE = 13'h010;
	localparam int BIT_SEP_OUT = 7;
	localparam int BIT_LSB_FIRST = 6;
	localparam int BIT_SOFT_RST = 5;
	localparam int BIT_RB_ACTIVE = 0;
	localparam int BIT_NV_WREN = 0;
	localparam int BIT_NV_LOAD = 1;
	localparam int BIT_NV_STORE = 0;
	localparam logic RST_SEP_OUT = 1'b0;
	localparam logic RST_LSB_FIRST = 1'b0;
	localparam logic RST_RB_ACTIVE = 1'b0;
	localparam logic RST_NV_BIT = 1'b0;
	localparam logic [7:0] RST_GEN = 8'h00;
	localparam int BIT_RW = 15;
	localparam int CNT_MSB = 14;
	localparam int CNT_LSB = 13;
	localparam logic [4:0] INSTR_LAST = 5'h0F;
	localparam logic [4:0] BYTE_LAST = 5'h07;
	localparam logic [1:0] CNT_STREAM = 2'h3;
	typedef struct packed {
		logic [12:0] addr;
		logic [7:0] data;
	} spcr_wr_s;
	typedef enum logic [1:0] {
		PH_INSTR = 2'b00,
		PH_TURN = 2'b01,
		PH_DATA = 2'b11,
		PH_DONE = 2'b10
	} spcr_phase_e;
endpackage : spcr_pkg

// *** verilog/spcr_link.sv ***
// Serial port shifter running on the serial clock.
module spcr_link import spcr_pkg::*; (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic link_rst_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	output logic sdo_out,
	output logic sdo_oe,
	input wire logic sep_lvl,
	input wire logic lsb_lvl,
	input wire logic two_wire_lvl,
	input wire logic [7:0] rd_data,
	output spcr_wr_s wr,
	output logic wr_tgl,
	output logic [12:0] rd_addr,
	output logic rd_tgl
);
	logic sep_m, sep_s, lsb_m, lsb_s, tw_m, tw_s, lsb_eff, bit_out, reading;
	spcr_phase_e ph_r, ph_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [15:0] sh_r, sh_nxt;
	logic rw_r, rw_nxt, wt_r, wt_nxt, rt_r, rt_nxt;
	logic [1:0] left_r, left_nxt;
	logic [12:0] addr_r, addr_nxt;
	spcr_wr_s wr_r, wr_nxt;
	logic [7:0] out_r, out_nxt;

	function automatic logic [12:0] step(input logic [12:0] a, input logic up);
		return up ? a + 13'h0001 : a - 13'h0001;
	endfunction : step

	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			{sep_m, sep_s, lsb_m, lsb_s, tw_m, tw_s} <= 6'h00;
		end else begin
			{sep_m, lsb_m, tw_m} <= {sep_lvl, lsb_lvl, two_wire_lvl};
			{sep_s, lsb_s, tw_s} <= {sep_m, lsb_m, tw_m};
		end
	end

	// Bit order and address direction only apply in four-wire mode.
	assign lsb_eff = lsb_s & ~tw_s;

	always_comb begin
		sh_nxt = lsb_eff ? {sdio_in, sh_r[15:1]} : {sh_r[14:0], sdio_in};
		ph_nxt = ph_r;
		cnt_nxt = cnt_r + 5'h01;
		rw_nxt = rw_r;
		left_nxt = left_r;
		addr_nxt = addr_r;
		wr_nxt = wr_r;
		wt_nxt = wt_r;
		rt_nxt = rt_r;
		if (!cs_n) begin
			case (ph_r)
				PH_INSTR: begin
					if (cnt_r == INSTR_LAST) begin
						cnt_nxt = 5'h00;
						rw_nxt = sh_nxt[BIT_RW];
						left_nxt = sh_nxt[CNT_MSB:CNT_LSB];
						addr_nxt = sh_nxt[AW-1:0];
						if (sh_nxt[BIT_RW]) begin
							ph_nxt = PH_TURN;
							rt_nxt = ~rt_r;
						end else begin
							ph_nxt = PH_DATA;
						end
					end
				end
				PH_TURN: begin
					ph_nxt = PH_DATA;
					cnt_nxt = 5'h00;
				end
				PH_DATA: begin
					// Fetch the next read byte a whole byte ahead of its use.
					if (rw_r && cnt_r == 5'h00) begin
						addr_nxt = step(addr_r, lsb_eff);
						rt_nxt = ~rt_r;
					end
					if (cnt_r == BYTE_LAST) begin
						cnt_nxt = 5'h00;
						if (!rw_r) begin
							wr_nxt.addr = addr_r;
							wr_nxt.data = lsb_eff ? sh_nxt[15:8] : sh_nxt[7:0];
							wt_nxt = ~wt_r;
							addr_nxt = step(addr_r, lsb_eff);
						end
						if (left_r == 2'h0) begin
							ph_nxt = PH_DONE;
						end else if (left_r != CNT_STREAM) begin
							left_nxt = left_r - 2'h1;
						end
					end
				end
				default: begin
					cnt_nxt = cnt_r;
				end
			endcase
		end
	end

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			ph_r <= PH_INSTR;
			cnt_r <= 5'h00;
			sh_r <= 16'h0000;
			rw_r <= 1'b0;
			left_r <= 2'h0;
		end else begin
			ph_r <= ph_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			rw_r <= rw_nxt;
			left_r <= left_nxt;
		end
	end

	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			addr_r <= 13'h0000;
			wr_r <= '0;
			wt_r <= 1'b0;
			rt_r <= 1'b0;
		end else begin
			addr_r <= addr_nxt;
			wr_r <= wr_nxt;
			wt_r <= wt_nxt;
			rt_r <= rt_nxt;
		end
	end

	always_comb begin
		if (ph_r == PH_DATA && cnt_r == 5'h00) begin
			out_nxt = rd_data;
		end else begin
			out_nxt = lsb_eff ? {1'b0, out_r[7:1]} : {out_r[6:0], 1'b0};
		end
	end

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			out_r <= 8'h00;
		end else begin
			out_r <= out_nxt;
		end
	end

	assign bit_out = lsb_eff ? out_r[0] : out_r[7];
	assign reading = rw_r && ph_r == PH_DATA && !cs_n;
	assign sdo_oe = reading & sep_s;
	assign sdio_oe = reading & ~sep_s;
	assign sdo_out = bit_out;
	assign sdio_out = bit_out;
	assign wr = wr_r;
	assign wr_tgl = wt_r;
	assign rd_addr = addr_r;
	assign rd_tgl = rt_r;

	// The mode level reaches the pins two serial clock edges after it is presented.
	sdo_mode_a: assert property (@(posedge sclk) disable iff (cs_n)
		sdo_oe |-> $past(sep_lvl, 2) && !sdio_oe)
		else $error("output pin driven outside separate output mode");
	bidir_mode_a: assert property (@(posedge sclk) disable iff (cs_n)
		sdio_oe |-> !$past(sep_lvl, 2) && !sdo_oe)
		else $error("data pin driven in separate output mode");
	two_wire_a: assert property (@(posedge sclk) disable iff (cs_n)
		(ph_r == PH_INSTR && cnt_r == 5'h00 && tw_s) |=> sh_r[0] == $past(sdio_in))
		else $error("bit order not forced in two-wire mode");
endmodule : spcr_link

// *** verilog/spcr_regs.sv ***
// Serial port configuration, variant, readback and nonvolatile store control registers.
// How it works
// - Port setup bit 7 picks bidirectional data pin or separate output pin for reads.
// - Port setup bit 6 picks MSB first with decrement or LSB first with increment.
// - Bit order and address direction are ignored while two-wire mode is selected.
// - Writing port setup bit 5 soft-resets; self-clearing; load pin high reloads store.
// - Soft reset with load pin low restores built-in defaults everywhere except the store contents.
// - Variant code is a read-only byte; writes to it are ignored.
// - Readback select bit 0 returns buffered values when low, active values when high.
module spcr_regs import spcr_pkg::*; #(
	parameter int GEN_N = 8,
	parameter logic [7:0] VARIANT_CODE = 8'h5A // Arbitrary value.
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	output logic sdo_out,
	output logic sdo_oe,
	input wire logic two_wire_mode,
	input wire logic nv_load_sel,
	input wire logic apply_update,
	output logic [GEN_N*8-1:0] active_regs
);
	localparam int GIW = $clog2(GEN_N);
	logic [2:0] tw_q, sel_q, app_q;
	logic [2:0] wt_q, rt_q;
	logic wr_ev, rd_ev, apply_ev, link_rst_n_r;
	spcr_wr_s wr;
	logic wr_tgl, rd_tgl;
	logic [12:0] rd_addr;
	logic sep_r, sep_nxt, lsb_r, lsb_nxt, rb_r, rb_nxt;
	logic wren_r, wren_nxt, load_r, load_nxt, store_r, store_nxt, soft_r, soft_nxt;
	logic [7:0] gen_buf_r [GEN_N];
	logic [7:0] gen_buf_nxt [GEN_N];
	logic [7:0] gen_act_r [GEN_N];
	logic [7:0] gen_act_nxt [GEN_N];
	logic [7:0] nv_gen_r [GEN_N];
	logic [7:0] nv_gen_nxt [GEN_N];
	logic [1:0] nv_cfg_r, nv_cfg_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;

	function automatic logic gen_hit(input logic [12:0] a);
		return a >= ADDR_GEN_BASE && a < ADDR_GEN_BASE + 13'(GEN_N);
	endfunction : gen_hit

	function automatic logic [GIW-1:0] gen_idx(input logic [12:0] a);
		logic [12:0] d;
		d = a - ADDR_GEN_BASE;
		return d[GIW-1:0];
	endfunction : gen_idx

	spcr_link u_link (
		.sclk(sclk),
		.cs_n(cs_n),
		.link_rst_n(link_rst_n_r),
		.sdio_in(sdio_in),
		.sdio_out(sdio_out),
		.sdio_oe(sdio_oe),
		.sdo_out(sdo_out),
		.sdo_oe(sdo_oe),
		.sep_lvl(sep_r),
		.lsb_lvl(lsb_r),
		.two_wire_lvl(tw_q[1]),
		.rd_data(rd_data_r),
		.wr(wr),
		.wr_tgl(wr_tgl),
		.rd_addr(rd_addr),
		.rd_tgl(rd_tgl)
	);

	// Pins and link toggles cross through two flops; the third stage only marks edges.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			{tw_q, sel_q, app_q, wt_q, rt_q} <= 15'h0000;
			link_rst_n_r <= 1'b0;
		end else begin
			tw_q <= {tw_q[1:0], two_wire_mode};
			sel_q <= {sel_q[1:0], nv_load_sel};
			app_q <= {app_q[1:0], apply_update};
			wt_q <= {wt_q[1:0], wr_tgl};
			rt_q <= {rt_q[1:0], rd_tgl};
			link_rst_n_r <= 1'b1;
		end
	end

	assign wr_ev = wt_q[2] ^ wt_q[1];
	assign rd_ev = rt_q[2] ^ rt_q[1];
	assign apply_ev = app_q[1] & ~app_q[2];

	always_comb begin
		rd_data_nxt = rd_data_r;
		if (rd_ev) begin
			rd_data_nxt = 8'h00;
			case (rd_addr)
				ADDR_PORT_SETUP: begin
					rd_data_nxt[BIT_SEP_OUT] = sep_r;
					rd_data_nxt[BIT_LSB_FIRST] = lsb_r;
					rd_data_nxt[7 - BIT_SEP_OUT] = sep_r;
					rd_data_nxt[7 - BIT_LSB_FIRST] = lsb_r;
				end
				ADDR_VARIANT: rd_data_nxt = VARIANT_CODE;
				ADDR_READBACK: rd_data_nxt[BIT_RB_ACTIVE] = rb_r;
				ADDR_NV_A: rd_data_nxt[BIT_NV_WREN] = wren_r;
				ADDR_NV_B: rd_data_nxt = 8'h00;
				default: begin
					if (gen_hit(rd_addr)) begin
						rd_data_nxt = rb_r ? gen_act_r[gen_idx(rd_addr)] : gen_buf_r[gen_idx(rd_addr)];
					end
				end
			endcase
		end
	end

	always_comb begin
		sep_nxt = sep_r;
		lsb_nxt = lsb_r;
		rb_nxt = rb_r;
		wren_nxt = wren_r;
		load_nxt = load_r;
		store_nxt = store_r;
		soft_nxt = 1'b0;
		gen_buf_nxt = gen_buf_r;
		gen_act_nxt = gen_act_r;
		nv_gen_nxt = nv_gen_r;
		nv_cfg_nxt = nv_cfg_r;
		if (apply_ev) begin
			gen_act_nxt = gen_buf_r;
		end
		if (load_r) begin
			gen_buf_nxt = nv_gen_r;
			gen_act_nxt = nv_gen_r;
			{sep_nxt, lsb_nxt} = nv_cfg_r;
			load_nxt = 1'b0;
		end
		if (store_r) begin
			if (wren_r) begin
				nv_gen_nxt = gen_buf_r;
				nv_cfg_nxt = {sep_r, lsb_r};
			end
			store_nxt = 1'b0;
		end
		// A trigger written in the cycle it clears is kept for another pass.
		if (wr_ev) begin
			case (wr.addr)
				ADDR_PORT_SETUP: begin
					sep_nxt = wr.data[BIT_SEP_OUT];
					lsb_nxt = wr.data[BIT_LSB_FIRST];
					soft_nxt = wr.data[BIT_SOFT_RST];
				end
				ADDR_READBACK: rb_nxt = wr.data[BIT_RB_ACTIVE];
				ADDR_NV_A: begin
					wren_nxt = wr.data[BIT_NV_WREN];
					load_nxt = load_nxt | wr.data[BIT_NV_LOAD];
				end
				ADDR_NV_B: store_nxt = store_nxt | wr.data[BIT_NV_STORE];
				default: begin
					if (gen_hit(wr.addr)) begin
						gen_buf_nxt[gen_idx(wr.addr)] = wr.data;
					end
				end
			endcase
		end
		if (soft_r) begin
			if (sel_q[1]) begin
				gen_buf_nxt = nv_gen_r;
				gen_act_nxt = nv_gen_r;
				{sep_nxt, lsb_nxt} = nv_cfg_r;
			end else begin
				gen_buf_nxt = '{default: RST_GEN};
				gen_act_nxt = '{default: RST_GEN};
				sep_nxt = RST_SEP_OUT;
				lsb_nxt = RST_LSB_FIRST;
			end
			rb_nxt = RST_RB_ACTIVE;
			wren_nxt = RST_NV_BIT;
			load_nxt = RST_NV_BIT;
			store_nxt = RST_NV_BIT;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			sep_r <= RST_SEP_OUT;
			lsb_r <= RST_LSB_FIRST;
			rb_r <= RST_RB_ACTIVE;
			wren_r <= RST_NV_BIT;
			load_r <= RST_NV_BIT;
			store_r <= RST_NV_BIT;
			soft_r <= 1'b0;
			gen_buf_r <= '{default: RST_GEN};
			gen_act_r <= '{default: RST_GEN};
			nv_gen_r <= '{default: RST_GEN};
			nv_cfg_r <= {RST_SEP_OUT, RST_LSB_FIRST};
			rd_data_r <= 8'h00;
		end else begin
			sep_r <= sep_nxt;
			lsb_r <= lsb_nxt;
			rb_r <= rb_nxt;
			wren_r <= wren_nxt;
			load_r <= load_nxt;
			store_r <= store_nxt;
			soft_r <= soft_nxt;
			gen_buf_r <= gen_buf_nxt;
			gen_act_r <= gen_act_nxt;
			nv_gen_r <= nv_gen_nxt;
			nv_cfg_r <= nv_cfg_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end

	always_comb begin
		for (int i = 0; i < GEN_N; i++) begin
			active_regs[i*8 +: 8] = gen_act_r[i];
		end
	end

	soft_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
		(wr_ev && wr.addr == ADDR_PORT_SETUP && wr.data[BIT_SOFT_RST]) |=> soft_r ##1 !soft_r)
		else $error("soft reset bit did not pulse and clear");
	soft_load_a: assert property (@(posedge clk) disable iff (!nrst)
		(soft_r && sel_q[1]) |=> gen_act_r[0] == $past(nv_gen_r[0]) && sep_r == $past(nv_cfg_r[1]))
		else $error("soft reset did not reload from store");
	soft_dflt_a: assert property (@(posedge clk) disable iff (!nrst)
		(soft_r && !sel_q[1]) |=> !sep_r && !lsb_r && !rb_r && gen_buf_r[0] == RST_GEN)
		else $error("soft reset did not restore defaults");
	variant_ro_a: assert property (@(posedge clk) disable iff (!nrst)
		(rd_ev && rd_addr == ADDR_VARIANT) |=> rd_data_r == VARIANT_CODE)
		else $error("variant code read wrong");
	rb_select_a: assert property (@(posedge clk) disable iff (!nrst)
		(rd_ev && rd_addr == ADDR_GEN_BASE) |=>
		rd_data_r == ($past(rb_r) ? $past(gen_act_r[0]) : $past(gen_buf_r[0])))
		else $error("readback source wrong");
	store_lock_a: assert property (@(posedge clk) disable iff (!nrst)
		(store_r && !wren_r) |=> $stable(nv_gen_r[0]) && $stable(nv_cfg_r))
		else $error("store written while locked");
	store_copy_a: assert property (@(posedge clk) disable iff (!nrst)
		(store_r && wren_r && !wr_ev) |=> nv_gen_r[0] == $past(gen_buf_r[0]) && !store_r)
		else $error("store copy or self-clear failed");
	load_copy_a: assert property (@(posedge clk) disable iff (!nrst)
		(load_r && !soft_r && !wr_ev) |=> gen_act_r[0] == $past(nv_gen_r[0]) && !load_r)
		else $error("load copy or self-clear failed");
	soft_c: cover property (@(posedge clk) disable iff (!nrst) soft_r && sel_q[1]);
	store_c: cover property (@(posedge clk) disable iff (!nrst) store_r && wren_r);
	load_c: cover property (@(posedge clk) disable iff (!nrst) load_r);
endmodule : spcr_regs

// *** sim/spcr_host.sv ***
// Host controller model that frames transfers on the serial port.
module spcr_host (
	output logic sclk,
	output logic cs_n,
	output logic sdio_d,
	input wire logic sdio_w,
	input wire logic sdo_w
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdio_d = 1'b0;
	end

	// Pulses with the frame closed let mode changes reach the serial clock domain.
	task automatic idle();
		repeat (3) begin
			#40 sclk = 1'b1;
			#40 sclk = 1'b0;
		end
	endtask : idle

	// First data byte travels in wd[15:8] and comes back in rdat[15:8].
	task automatic xfer(input logic rd, input logic lsb, input logic sep, input logic [12:0] a,
		input logic [1:0] cnt, input logic [15:0] wd, output logic [15:0] rdat);
		logic [15:0] ins;
		ins = {rd, cnt, a};
		rdat = 16'h0000;
		cs_n = 1'b0;
		for (int i = 0; i < 16; i++) begin
			sdio_d = lsb ? ins[i] : ins[15 - i];
			#40 sclk = 1'b1;
			#40 sclk = 1'b0;
		end
		if (rd) begin
			// A released data line toggles so a stale level never passes for read data.
			sdio_d = ~sdio_d;
			#40 sclk = 1'b1;
			#40 sclk = 1'b0;
		end
		for (int i = 0; i < 8 * (int'(cnt) + 1); i++) begin
			int k;
			k = 15 - ((i / 8) * 8 + (lsb ? 7 - i % 8 : i % 8));
			// Bytes past the second are clocked through but not kept.
			sdio_d = rd ? ~sdio_d : (k >= 0 ? wd[k] : 1'b0);
			#40 sclk = 1'b1;
			if (rd && k >= 0) rdat[k] = sep ? sdo_w : sdio_w;
			#40 sclk = 1'b0;
		end
		#20 cs_n = 1'b1;
		idle();
	endtask : xfer
endmodule : spcr_host

// *** sim/spcr_regs_tb.sv ***
// Self-checking testbench for the serial port configuration registers.
module spcr_regs_tb import spcr_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] VAR = 8'h3C; // Arbitrary value.
	logic clk, nrst, two_wire_mode, nv_load_sel, apply_update, sep_exp;
	logic sclk, cs_n, sdio_d, sdio_out, sdio_oe, sdo_out, sdo_oe;
	logic [63:0] active_regs;
	logic [15:0] rdat;
	wire sdio_w;
	wire sdo_w;
	int n_fail, num_checks, bad_oe;

	assign sdio_w = sdio_oe ? sdio_out : sdio_d;
	// The output pin has no keeper, so it floats when the device lets go.
	assign sdo_w = sdo_oe ? sdo_out : 1'bz;

	spcr_regs #(.GEN_N(8), .VARIANT_CODE(VAR)) dut_u (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
		.sdio_in(sdio_w), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
		.two_wire_mode(two_wire_mode), .nv_load_sel(nv_load_sel), .apply_update(apply_update),
		.active_regs(active_regs));
	spcr_host host_u (.sclk(sclk), .cs_n(cs_n), .sdio_d(sdio_d), .sdio_w(sdio_w), .sdo_w(sdo_w));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (nrst && ((sdio_oe !== 1'b0 && sep_exp) || (sdo_oe !== 1'b0 && !sep_exp))) bad_oe++;
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic lsb, input logic [12:0] a, input logic [7:0] d);
		host_u.xfer(1'b0, lsb, 1'b0, a, 2'h0, {d, 8'h00}, rdat);
	endtask : wr

	task automatic rd(input logic lsb, input logic [12:0] a, input logic [7:0] e, input string nm);
		host_u.xfer(1'b1, lsb, sep_exp, a, 2'h0, 16'h0000, rdat);
		chk(nm, e, rdat[15:8]);
	endtask : rd

	task automatic pins(input logic tw, input logic ls, input logic au);
		@(negedge clk);
		two_wire_mode = tw;
		nv_load_sel = ls;
		apply_update = au;
		repeat (8) @(negedge clk);
		host_u.idle();
	endtask : pins

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	initial begin
		#300000;
		n_fail++;
		$display("[ERR] run expected end seen timeout");
		final_report();
	end

	initial begin
		nrst = 1'b0;
		two_wire_mode = 1'b0;
		nv_load_sel = 1'b0;
		apply_update = 1'b0;
		sep_exp = 1'b0;
		n_fail = 0;
		num_checks = 0;
		bad_oe = 0;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		rd(1'b0, ADDR_PORT_SETUP, 8'h00, "port_setup");
		rd(1'b0, ADDR_READBACK, 8'h00, "readback_source");
		rd(1'b0, ADDR_NV_A, 8'h00, "nv_store_control_a");
		rd(1'b0, ADDR_NV_B, 8'h00, "nv_store_control_b");
		rd(1'b0, ADDR_VARIANT, VAR, "variant_code");
		wr(1'b0, ADDR_VARIANT, 8'hFF);
		rd(1'b0, ADDR_VARIANT, VAR, "variant_code after write");
		wr(1'b0, 13'h100, 8'h99);
		rd(1'b0, 13'h100, 8'h00, "unmapped");
		$display("test reset and read-only done");
		host_u.xfer(1'b0, 1'b0, 1'b0, ADDR_GEN_BASE + 13'h2, 2'h1, 16'h1122, rdat);
		rd(1'b0, ADDR_GEN_BASE + 13'h2, 8'h11, "msb first byte");
		rd(1'b0, ADDR_GEN_BASE + 13'h1, 8'h22, "decremented byte");
		host_u.xfer(1'b1, 1'b0, 1'b0, ADDR_GEN_BASE + 13'h2, CNT_STREAM, 16'h0000, rdat);
		chk("stream first byte", 8'h11, rdat[15:8]);
		chk("stream second byte", 8'h22, rdat[7:0]);
		$display("test msb decrement done");
		wr(1'b0, ADDR_GEN_BASE, 8'hA5);
		wr(1'b0, ADDR_READBACK, 8'h01);
		rd(1'b0, ADDR_GEN_BASE, 8'h00, "active before apply");
		pins(1'b0, 1'b0, 1'b1);
		pins(1'b0, 1'b0, 1'b0);
		chk("active_regs", 8'hA5, active_regs[7:0]);
		rd(1'b0, ADDR_GEN_BASE, 8'hA5, "active after apply");
		wr(1'b0, ADDR_READBACK, 8'h00);
		$display("test readback source done");
		wr(1'b0, ADDR_PORT_SETUP, 8'h81);
		sep_exp = 1'b1;
		rd(1'b0, ADDR_VARIANT, VAR, "variant on output pin");
		wr(1'b0, ADDR_PORT_SETUP, 8'h00);
		sep_exp = 1'b0;
		rd(1'b0, ADDR_VARIANT, VAR, "variant on data pin");
		chk("pin enables", 8'h00, {7'h00, bad_oe != 0});
		$display("test output pin done");
		wr(1'b0, ADDR_PORT_SETUP, 8'h42);
		host_u.xfer(1'b0, 1'b1, 1'b0, ADDR_GEN_BASE + 13'h3, 2'h1, 16'h3344, rdat);
		rd(1'b1, ADDR_GEN_BASE + 13'h4, 8'h44, "incremented byte");
		rd(1'b1, ADDR_PORT_SETUP, 8'h42, "port_setup lsb");
		pins(1'b1, 1'b0, 1'b0);
		rd(1'b0, ADDR_GEN_BASE + 13'h3, 8'h33, "two-wire msb");
		pins(1'b0, 1'b0, 1'b0);
		wr(1'b1, ADDR_PORT_SETUP, 8'h00);
		$display("test lsb increment done");
		wr(1'b0, ADDR_GEN_BASE, 8'h77);
		pins(1'b0, 1'b0, 1'b1);
		pins(1'b0, 1'b0, 1'b0);
		wr(1'b0, ADDR_NV_A, 8'h01);
		wr(1'b0, ADDR_NV_B, 8'h01);
		rd(1'b0, ADDR_NV_B, 8'h00, "store trigger");
		wr(1'b0, ADDR_GEN_BASE, 8'h00);
		wr(1'b0, ADDR_NV_A, 8'h03);
		rd(1'b0, ADDR_NV_A, 8'h01, "load trigger");
		rd(1'b0, ADDR_GEN_BASE, 8'h77, "loaded byte");
		chk("active after load", 8'h77, active_regs[7:0]);
		wr(1'b0, ADDR_NV_A, 8'h00);
		wr(1'b0, ADDR_GEN_BASE, 8'h11);
		wr(1'b0, ADDR_NV_B, 8'h01);
		wr(1'b0, ADDR_PORT_SETUP, 8'h24);
		rd(1'b0, ADDR_GEN_BASE, 8'h00, "default byte");
		chk("active after default", 8'h00, active_regs[7:0]);
		rd(1'b0, ADDR_PORT_SETUP, 8'h00, "soft reset bit");
		pins(1'b0, 1'b1, 1'b0);
		wr(1'b0, ADDR_PORT_SETUP, 8'h24);
		rd(1'b0, ADDR_GEN_BASE, 8'h77, "reloaded byte");
		chk("active after reload", 8'h77, active_regs[7:0]);
		$display("test store and soft reset done");
		final_report();
	end
endmodule : spcr_regs_tb
